// >>> sfe_device.sv
// Flash end: erase command decode, self-timed erase, suspend and resume
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "sfe_params.svh"

module sfe_device #(
	parameter int T_SECTOR_US  = 400,
	parameter int T_B32_US     = 1200,
	parameter int T_B64_US     = 1600,
	parameter int T_CHIP_US    = 8000,
	parameter int T_SUSPEND_US = 20
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	sfe_link_if.dev                  link,
	input  wire logic                addr4_mode,
	input  wire logic                protect_complement,
	input  wire logic                protect_top_bottom,
	input  wire logic                protect_range_bit3,
	input  wire logic                protect_range_bit2,
	input  wire logic                protect_range_bit1,
	input  wire logic                protect_range_bit0,
	input  wire logic [15:0]         region_lock,
	output logic                     busy,
	output logic                     write_enable_latch,
	output logic                     paused_flag,
	output logic                     erase_done,
	output sfe_pkg::sfe_kind_t       erase_kind,
	output logic [31:0]              erase_base
);

	//------------------------------------------------------------------
	// Derived cycle counts
	//------------------------------------------------------------------
	localparam int CYC_US       = 1000 / `SFE_CLK_NS;
	localparam int SECTOR_CYC   = T_SECTOR_US * CYC_US;
	localparam int B32_CYC      = T_B32_US * CYC_US;
	localparam int B64_CYC      = T_B64_US * CYC_US;
	localparam int CHIP_CYC     = T_CHIP_US * CYC_US;
	localparam int SUSPEND_CYC  = T_SUSPEND_US * CYC_US;

	//------------------------------------------------------------------
	// Link synchronisers
	//------------------------------------------------------------------
	logic [2:0] sck_sync_q;
	logic [1:0] cs_sync_q;
	logic       cs_prev_q;
	logic [1:0] mosi_sync_q;

	// Two flops per pin, a third on clock and select for edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_sync_q  <= 3'h0;
			cs_sync_q   <= 2'h3;
			cs_prev_q   <= 1'b1;
			mosi_sync_q <= 2'h0;
		end else begin
			sck_sync_q  <= {sck_sync_q[1:0], link.sck};
			cs_sync_q   <= {cs_sync_q[0], link.cs_n};
			cs_prev_q   <= cs_sync_q[1];
			mosi_sync_q <= {mosi_sync_q[0], link.mosi};
		end
	end

	logic sck_rise;
	logic sck_fall;
	logic frame_on;
	logic frame_end;
	logic frame_start;

	assign sck_rise    = sck_sync_q[1] & ~sck_sync_q[2];
	assign sck_fall    = ~sck_sync_q[1] & sck_sync_q[2];
	assign frame_on    = ~cs_sync_q[1];
	assign frame_end   = cs_sync_q[1] & ~cs_prev_q;
	assign frame_start = ~cs_sync_q[1] & cs_prev_q;

	//------------------------------------------------------------------
	// Frame shifter
	//------------------------------------------------------------------
	logic [39:0] shift_q;
	logic [5:0]  bits_q;
	logic        ovf_q;

	// Count and collect bits on each rising link clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_q <= 40'h0;
			bits_q  <= 6'h0;
			ovf_q   <= 1'b0;
		end else if (frame_start) begin
			bits_q <= 6'h0;
			ovf_q  <= 1'b0;
		end else if (frame_on && sck_rise) begin
			shift_q <= {shift_q[38:0], mosi_sync_q[1]};
			if (bits_q == 6'h3f)
				ovf_q <= 1'b1;
			else
				bits_q <= bits_q + 6'h1;
		end
	end

	// Opcode sits in different places depending on frame length
	logic [7:0]  opcode;
	logic [31:0] addr;
	logic [5:0]  need_bits;
	logic        is_erase;
	sfe_pkg::sfe_kind_t kind;

	always_comb begin
		opcode    = shift_q[7:0];
		addr      = 32'h0;
		need_bits = `SFE_BITS_OP;
		is_erase  = 1'b0;
		kind      = sfe_pkg::SFE_K_CHIP;
		if (bits_q == `SFE_BITS_A4) begin
			opcode = shift_q[39:32];
			addr   = shift_q[31:0];
		end else if (bits_q == `SFE_BITS_A3) begin
			opcode = shift_q[31:24];
			addr   = {8'h00, shift_q[23:0]};
		end
		case (opcode)
			`SFE_OP_SE, `SFE_OP_BE32, `SFE_OP_BE64: begin
				need_bits = addr4_mode ? `SFE_BITS_A4 : `SFE_BITS_A3;
				is_erase  = 1'b1;
			end
			`SFE_OP_SE4, `SFE_OP_BE64_4: begin
				need_bits = `SFE_BITS_A4;
				is_erase  = 1'b1;
			end
			`SFE_OP_CE_A, `SFE_OP_CE_B: begin
				is_erase = 1'b1;
			end
			// Status write and program opcodes never act, paused or not
			default: begin
				need_bits = `SFE_BITS_OP;
			end
		endcase
		case (opcode)
			`SFE_OP_SE, `SFE_OP_SE4: kind = sfe_pkg::SFE_K_SECTOR;
			`SFE_OP_BE32:            kind = sfe_pkg::SFE_K_B32;
			`SFE_OP_BE64, `SFE_OP_BE64_4: kind = sfe_pkg::SFE_K_B64;
			default:                 kind = sfe_pkg::SFE_K_CHIP;
		endcase
	end

	// Complete frame: select rose exactly after the last full byte
	logic cmd_ok;
	assign cmd_ok = frame_end && !ovf_q && (bits_q == need_bits);

	//------------------------------------------------------------------
	// Protection
	//------------------------------------------------------------------
	logic [3:0] prot_range;
	logic       range_hit;
	logic       target_prot;
	logic       any_prot;

	// Range from the half chosen by top/bottom, inverted by complement
	always_comb begin
		prot_range  = {protect_range_bit3, protect_range_bit2,
			protect_range_bit1, protect_range_bit0};
		range_hit   = (|prot_range) &
			(protect_top_bottom ? ~addr[`SFE_ADDR_MSB] : addr[`SFE_ADDR_MSB]);
		target_prot = (range_hit ^ protect_complement)
			| region_lock[addr[`SFE_ADDR_MSB:`SFE_LOCK_LSB]];
		any_prot    = (|prot_range) | protect_complement | (|region_lock);
	end

	logic blocked;
	assign blocked = (kind == sfe_pkg::SFE_K_CHIP) ? any_prot : target_prot;

	//------------------------------------------------------------------
	// Erase engine
	//------------------------------------------------------------------
	logic [31:0] remain_q;
	logic [31:0] sus_cnt_q;
	logic        suspending_q;
	logic [31:0] load_cyc;
	logic [31:0] load_mask;

	always_comb begin
		case (kind)
			sfe_pkg::SFE_K_SECTOR: begin
				load_cyc  = 32'(SECTOR_CYC);
				load_mask = `SFE_MASK_4K;
			end
			sfe_pkg::SFE_K_B32: begin
				load_cyc  = 32'(B32_CYC);
				load_mask = `SFE_MASK_32K;
			end
			sfe_pkg::SFE_K_B64: begin
				load_cyc  = 32'(B64_CYC);
				load_mask = `SFE_MASK_64K;
			end
			default: begin
				load_cyc  = 32'(CHIP_CYC);
				load_mask = 32'h0;
			end
		endcase
	end

	logic do_erase;
	logic do_suspend;
	logic do_resume;
	logic finish;

	assign do_erase   = cmd_ok && is_erase && !busy && !paused_flag
		&& write_enable_latch && !blocked;
	assign do_suspend = cmd_ok && (opcode == `SFE_OP_SUSPEND) && busy && !paused_flag
		&& (erase_kind != sfe_pkg::SFE_K_CHIP);
	assign do_resume  = cmd_ok && (opcode == `SFE_OP_RESUME) && paused_flag && !busy;
	assign finish     = busy && !paused_flag && (remain_q == 32'h1);

	// Busy, paused flag, time left; reset clears the pause as power loss does
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy         <= 1'b0;
			paused_flag  <= 1'b0;
			remain_q     <= 32'h0;
			sus_cnt_q    <= 32'h0;
			suspending_q <= 1'b0;
		end else if (do_erase) begin
			busy     <= 1'b1;
			remain_q <= load_cyc;
		end else if (do_suspend) begin
			paused_flag  <= 1'b1;
			suspending_q <= 1'b1;
			sus_cnt_q    <= 32'(SUSPEND_CYC);
		end else if (suspending_q) begin
			if (sus_cnt_q <= 32'h1) begin
				busy         <= 1'b0;
				suspending_q <= 1'b0;
			end else begin
				sus_cnt_q <= sus_cnt_q - 32'h1;
			end
		end else if (do_resume) begin
			paused_flag <= 1'b0;
			busy        <= 1'b1;
		end else if (finish) begin
			busy     <= 1'b0;
			remain_q <= 32'h0;
		end else if (busy && !paused_flag) begin
			remain_q <= remain_q - 32'h1;
		end
	end

	// Target and kind held through a pause
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			erase_kind <= sfe_pkg::SFE_K_SECTOR;
			erase_base <= 32'h0;
		end else if (do_erase) begin
			erase_kind <= kind;
			erase_base <= addr & load_mask;
		end
	end

	// One-cycle pulse when the array region has been set to FFh
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			erase_done <= 1'b0;
		else
			erase_done <= finish;
	end

	// Write enable latch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			write_enable_latch <= 1'b0;
		else if (finish)
			write_enable_latch <= 1'b0;
		else if (cmd_ok && opcode == `SFE_OP_WREN && !busy)
			write_enable_latch <= 1'b1;
		else if (cmd_ok && opcode == `SFE_OP_WRDI && !busy)
			write_enable_latch <= 1'b0;
	end

	//------------------------------------------------------------------
	// Status read-out
	//------------------------------------------------------------------
	logic [7:0] status_byte;
	logic [7:0] sr_shift_q;
	logic       miso_q;

	always_comb begin
		status_byte                 = 8'h00;
		status_byte[`SFE_SR_BUSY]   = busy;
		status_byte[`SFE_SR_WEL]    = write_enable_latch;
		status_byte[`SFE_SR_PAUSED] = paused_flag;
	end

	// Status loads after each 05h byte in, then shifts out MSB first on each falling clock, also while busy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sr_shift_q <= 8'h00;
			miso_q     <= 1'b0;
		end else if (frame_on && sck_fall && bits_q >= `SFE_BITS_OP
			&& shift_q[7:0] == `SFE_OP_RDSR && bits_q[2:0] == 3'h0) begin
			miso_q     <= status_byte[7];
			sr_shift_q <= {status_byte[6:0], 1'b0};
		end else if (frame_on && sck_fall && bits_q > `SFE_BITS_OP) begin
			miso_q     <= sr_shift_q[7];
			sr_shift_q <= {sr_shift_q[6:0], 1'b0};
		end
	end

	assign link.miso = miso_q;

endmodule : sfe_device

// >>> sfe_params.svh
// Constants for the serial flash erase, suspend and resume design
//------------------------------------------------------------------
// Overview of operation
// - 20h erases addressed 4KB sector to FFh
// - 21h and DCh always take 32-bit address
// - 52h erases addressed 32KB block to FFh
// - D8h erases addressed 64KB block
// - C7h or 60h erases whole array
// - Erase needs write enable latch set first
// - Host shifts 24 or 32 address bits
// - Select rises on byte boundary or discard
// - Read status accepted during running erase
// - Busy high for whole erase cycle
// - Finished erase clears write enable latch
// - Protected sector or block erase skipped
// - Chip erase skipped if anything protected
// - 75h pauses sector or block erase
// - Erases and status write refused while paused
// - Erase suspend blocks program opcodes
// - Suspend ignored during chip erase
// - Suspend accepted only when unpaused and busy
// - Paused flag now, busy clears within latency
// - Host waits suspend latency after resume
// - Resume accepted only when paused, not busy
// - Resume clears flag, sets busy, completes
// - Power loss clears paused flag
//------------------------------------------------------------------
`ifndef SFE_PARAMS_SVH
`define SFE_PARAMS_SVH

// Opcodes
`define SFE_OP_WREN     8'h06
`define SFE_OP_WRDI     8'h04
`define SFE_OP_RDSR     8'h05
`define SFE_OP_SE       8'h20
`define SFE_OP_SE4      8'h21
`define SFE_OP_BE32     8'h52
`define SFE_OP_BE64     8'hd8
`define SFE_OP_BE64_4   8'hdc
`define SFE_OP_CE_A     8'hc7
`define SFE_OP_CE_B     8'h60
`define SFE_OP_SUSPEND  8'h75
`define SFE_OP_RESUME   8'h7a

// Status byte fields
`define SFE_SR_BUSY     0
`define SFE_SR_WEL      1
`define SFE_SR_PAUSED   7

// Frame lengths in link bits
`define SFE_BITS_OP     6'd8
`define SFE_BITS_A3     6'd32
`define SFE_BITS_A4     6'd40

// Array geometry: 32 MB, 16 lock regions of 2 MB
`define SFE_ADDR_MSB    24
`define SFE_LOCK_LSB    21
`define SFE_MASK_4K     32'hffff_f000
`define SFE_MASK_32K    32'hffff_8000
`define SFE_MASK_64K    32'hffff_0000

// Timing
`define SFE_CLK_NS      40
`define SFE_SCK_HALF    4'h8

// Controller register offsets and fields
`define SFE_REG_CMD     12'h000
`define SFE_REG_ADDR    12'h004
`define SFE_REG_STATUS  12'h008
`define SFE_CMD_NAB_LSB 8
`define SFE_CMD_RD_BIT  11

`endif

// >>> sfe_pkg.sv
// Types shared by both ends of the serial flash erase link
package sfe_pkg;

	// Kind of self-timed erase
	typedef enum logic [1:0] {
		SFE_K_SECTOR = 2'b00,
		SFE_K_B32    = 2'b01,
		SFE_K_B64    = 2'b10,
		SFE_K_CHIP   = 2'b11
	} sfe_kind_t;

	// Controller sequencer states
	typedef enum logic [1:0] {
		SFE_H_IDLE  = 2'b00,
		SFE_H_SETUP = 2'b01,
		SFE_H_SHIFT = 2'b10,
		SFE_H_END   = 2'b11
	} sfe_hstate_t;

endpackage : sfe_pkg

// >>> sfe_link_if.sv
// Serial link between the controller and the flash
`timescale 1ns/100ps

interface sfe_link_if;
	logic cs_n;
	logic sck;
	logic mosi;
	logic miso;

	modport dev (
		input  cs_n,
		input  sck,
		input  mosi,
		output miso
	);

	modport host (
		output cs_n,
		output sck,
		output mosi,
		input  miso
	);
endinterface : sfe_link_if

// >>> sfe_host.sv
// Controller end: APB registers drive erase and status frames on the link
`timescale 1ns/100ps
`include "sfe_params.svh"

module sfe_host (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	sfe_link_if.host         link
);

	sfe_pkg::sfe_hstate_t state_q;
	logic [31:0] addr_q;
	logic [7:0]  rx_q;
	logic [39:0] tx_q;
	logic [5:0]  bits_left_q;
	logic        rd_q;
	logic [3:0]  div_q;
	logic        cs_n_q;
	logic        sck_q;
	logic        mosi_q;
	logic [1:0]  miso_sync_q;

	//------------------------------------------------------------------
	// APB slave
	//------------------------------------------------------------------
	logic wr_en;
	logic start;
	logic [2:0] nab;

	assign wr_en = psel && penable && pwrite;
	assign start = wr_en && paddr == `SFE_REG_CMD && state_q == sfe_pkg::SFE_H_IDLE;
	assign nab   = pwdata[`SFE_CMD_NAB_LSB +: 3];

	// Zero-wait answers; unmapped reads give zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			case (paddr)
				`SFE_REG_ADDR:   prdata <= addr_q;
				`SFE_REG_STATUS: prdata <= {16'h0, rx_q, 7'h0,
					state_q != sfe_pkg::SFE_H_IDLE};
				default:         prdata <= 32'h0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			addr_q <= 32'h0;
		else if (wr_en && paddr == `SFE_REG_ADDR)
			addr_q <= pwdata;
	end

	//------------------------------------------------------------------
	// Frame sequencer; link clock is pclk divided by twice SCK_HALF
	//------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			miso_sync_q <= 2'h0;
		else
			miso_sync_q <= {miso_sync_q[0], link.miso};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q     <= sfe_pkg::SFE_H_IDLE;
			tx_q        <= 40'h0;
			bits_left_q <= 6'h0;
			rd_q        <= 1'b0;
			div_q       <= 4'h0;
			cs_n_q      <= 1'b1;
			sck_q       <= 1'b0;
			mosi_q      <= 1'b0;
			rx_q        <= 8'h0;
		end else begin
			case (state_q)
				sfe_pkg::SFE_H_IDLE: begin
					if (start) begin
						// 4-byte ops always carry 32 bits when nab is 4
						tx_q <= (nab == 3'h4) ? {pwdata[7:0], addr_q}
							: {pwdata[7:0], addr_q[23:0], 8'h00};
						bits_left_q <= 6'(8 * (32'(nab) + 1))
							+ (pwdata[`SFE_CMD_RD_BIT] ? 6'h8 : 6'h0);
						rd_q    <= pwdata[`SFE_CMD_RD_BIT];
						cs_n_q  <= 1'b0;
						div_q   <= 4'h0;
						state_q <= sfe_pkg::SFE_H_SETUP;
					end
				end
				sfe_pkg::SFE_H_SETUP: begin
					mosi_q  <= tx_q[39];
					tx_q    <= {tx_q[38:0], 1'b0};
					state_q <= sfe_pkg::SFE_H_SHIFT;
				end
				sfe_pkg::SFE_H_SHIFT: begin
					if (div_q == `SFE_SCK_HALF - 4'h1) begin
						div_q <= 4'h0;
						sck_q <= ~sck_q;
						if (!sck_q) begin
							rx_q <= {rx_q[6:0], miso_sync_q[1]};
						end else if (bits_left_q == 6'h1) begin
							// Select rises only after whole bytes
							state_q <= sfe_pkg::SFE_H_END;
						end else begin
							bits_left_q <= bits_left_q - 6'h1;
							mosi_q      <= tx_q[39];
							tx_q        <= {tx_q[38:0], 1'b0};
						end
					end else begin
						div_q <= div_q + 4'h1;
					end
				end
				sfe_pkg::SFE_H_END: begin
					if (div_q == `SFE_SCK_HALF - 4'h1) begin
						div_q <= 4'h0;
						if (cs_n_q)
							state_q <= sfe_pkg::SFE_H_IDLE;
						cs_n_q <= 1'b1;
					end else begin
						div_q <= div_q + 4'h1;
					end
				end
				default: state_q <= sfe_pkg::SFE_H_IDLE;
			endcase
		end
	end

	assign link.cs_n = cs_n_q;
	assign link.sck  = sck_q;
	assign link.mosi = mosi_q;

endmodule : sfe_host

// >>> sfe_props.sv
// Link and flash status checks for the serial flash erase link
`timescale 1ns/100ps

module sfe_props #(
	parameter int T_SUSPEND_US = 1
) (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               cs_n,
	input wire logic               sck,
	input wire logic               busy,
	input wire logic               write_enable_latch,
	input wire logic               paused_flag,
	input wire logic               erase_done,
	input wire sfe_pkg::sfe_kind_t erase_kind
);
	// Suspend latency in cycles, with slack for the link sampling
	localparam int SUS_MAX = T_SUSPEND_US * 25 + 8;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	//------------------------------------------------------------
	// Named steps
	//------------------------------------------------------------
	sequence s_suspend_taken;
		$rose(paused_flag) ##0 busy;
	endsequence
	sequence s_erase_start;
		$rose(busy) ##0 !$fell(paused_flag);
	endsequence

	a_sck_idle_low: assert property (cs_n |-> !sck)
		else $error("link clock high while deselected");
	a_start_after_sel: assert property (s_erase_start |-> cs_n)
		else $error("erase started with select low");
	a_start_needs_wel: assert property (s_erase_start |-> $past(write_enable_latch))
		else $error("erase started without write enable");
	a_done_clears: assert property (erase_done |-> ##[0:1] (!busy && !write_enable_latch))
		else $error("busy or write enable left after erase");
	a_done_single: assert property (erase_done |=> !erase_done)
		else $error("erase done longer than one cycle");
	a_pause_when_busy: assert property ($rose(paused_flag) |-> $past(busy))
		else $error("suspend taken while idle");
	a_pause_no_chip: assert property (s_suspend_taken |-> erase_kind != sfe_pkg::SFE_K_CHIP)
		else $error("whole array erase suspended");
	a_pause_drops_busy: assert property (s_suspend_taken |-> ##[1:SUS_MAX] !busy)
		else $error("busy not cleared within suspend latency");
	a_no_erase_paused: assert property ($rose(busy) |-> !paused_flag)
		else $error("erase began while paused");
	a_resume_busy: assert property ($fell(paused_flag) |-> ##[0:4] busy)
		else $error("busy not set after resume");
	a_resume_idle: assert property ($fell(paused_flag) |-> !$past(busy))
		else $error("resume taken while busy");
endmodule : sfe_props

// >>> serial_flash_erase_suspend_resume_bench.sv
// Self-checking bench: controller and flash joined over the serial link
`timescale 1ns/100ps
`include "sfe_params.svh"

module serial_flash_erase_suspend_resume_bench;
	logic               pclk, presetn, psel, penable, pwrite, addr4_mode, pready;
	logic               busy, write_enable_latch, paused_flag, erase_done;
	logic [11:0]        paddr;
	logic [31:0]        pwdata, prdata, last_st, erase_base, a;
	logic [5:0]         prot;
	logic [15:0]        region_lock;
	logic [47:0]        sh;
	logic [7:0]         op;
	logic [7:0]         ops [7] = '{8'h20, 8'h21, 8'h52, 8'hd8, 8'hdc, 8'hc7, 8'h60};
	sfe_pkg::sfe_kind_t erase_kind;
	int                 nbits, error_cnt, comparisons;

	sfe_link_if lk ();
	sfe_device #(.T_SECTOR_US(20), .T_B32_US(24), .T_B64_US(28), .T_CHIP_US(32),
		.T_SUSPEND_US(1)) sfe_device_inst (.pclk(pclk), .presetn(presetn), .link(lk),
		.addr4_mode(addr4_mode), .protect_complement(prot[5]), .protect_top_bottom(prot[4]),
		.protect_range_bit3(prot[3]), .protect_range_bit2(prot[2]),
		.protect_range_bit1(prot[1]), .protect_range_bit0(prot[0]),
		.region_lock(region_lock), .busy(busy), .write_enable_latch(write_enable_latch),
		.paused_flag(paused_flag), .erase_done(erase_done), .erase_kind(erase_kind),
		.erase_base(erase_base));
	sfe_host sfe_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(), .link(lk));
	sfe_props #(.T_SUSPEND_US(1)) sfe_props_inst (.pclk(pclk), .presetn(presetn),
		.cs_n(lk.cs_n), .sck(lk.sck), .busy(busy), .write_enable_latch(write_enable_latch),
		.paused_flag(paused_flag), .erase_done(erase_done), .erase_kind(erase_kind));

	// Clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// Wire monitor: bits shifted while selected
	always @(negedge lk.cs_n) nbits <= 0;
	always @(posedge lk.sck) if (lk.cs_n === 1'b0) begin
		sh <= {sh[46:0], lk.mosi};
		nbits <= nbits + 1;
	end

	//------------------------------------------------------------
	// Tasks and expectations
	//------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : tally_and_finish

	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		last_st = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Launch a frame, wait for its end, check what went on the wire
	task automatic frame(input logic [7:0] o, input logic [2:0] nab, input logic rd,
		input logic [31:0] ad);
		int n;
		int s;
		s = rd ? 8 : 0;
		apb(1'b1, `SFE_REG_ADDR, ad);
		apb(1'b1, `SFE_REG_CMD, {20'h0, rd, nab, o});
		n = 0;
		while (lk.cs_n !== 1'b0 && n < 100) begin
			@(posedge pclk);
			n++;
		end
		last_st = 32'h1;
		while (last_st[0] !== 1'b0) apb(1'b0, `SFE_REG_STATUS, 32'h0);
		repeat (8) @(posedge pclk);
		chk("bit count", nbits, 8 + 8 * nab + s);
		chk("opcode", 32'((sh >> (8 * nab + s)) & 48'hff), o);
		if (nab != 0) chk("address", 32'(sh >> s) & (nab == 4 ? 32'hffffffff : 32'hffffff),
			ad & (nab == 4 ? 32'hffffffff : 32'hffffff));
	endtask : frame

	function automatic logic [2:0] nab_of(input logic [7:0] o);
		if (o == 8'hc7 || o == 8'h60) return 3'd0;
		return (o == 8'h21 || o == 8'hdc || addr4_mode) ? 3'd4 : 3'd3;
	endfunction : nab_of

	function automatic sfe_pkg::sfe_kind_t kind_of(input logic [7:0] o);
		case (o)
			8'h20, 8'h21: return sfe_pkg::SFE_K_SECTOR;
			8'h52: return sfe_pkg::SFE_K_B32;
			8'hd8, 8'hdc: return sfe_pkg::SFE_K_B64;
			default: return sfe_pkg::SFE_K_CHIP;
		endcase
	endfunction : kind_of

	function automatic logic [31:0] base_of(input logic [7:0] o, input logic [31:0] ad);
		logic [31:0] m;
		m = (nab_of(o) == 3'd4) ? ad : (ad & 32'h00ff_ffff);
		case (kind_of(o))
			sfe_pkg::SFE_K_SECTOR: return m & `SFE_MASK_4K;
			sfe_pkg::SFE_K_B32: return m & `SFE_MASK_32K;
			sfe_pkg::SFE_K_B64: return m & `SFE_MASK_64K;
			default: return 32'h0;
		endcase
	endfunction : base_of

	// Target protected by range bits on the chosen half, inverted by complement
	function automatic logic prot_of(input logic [5:0] p, input logic [31:0] ad);
		return ((|p[3:0]) && (p[4] ? !ad[24] : ad[24])) ^ p[5];
	endfunction : prot_of

	task automatic erase(input logic [7:0] o, input logic [31:0] ad);
		frame(`SFE_OP_WREN, 3'd0, 1'b0, 32'h0);
		frame(o, nab_of(o), 1'b0, ad);
	endtask : erase

	task automatic wait_flag(input logic want_done);
		int n;
		n = 0;
		while ((want_done ? erase_done !== 1'b1 : busy !== 1'b0) && n < 5000) begin
			@(posedge pclk);
			n++;
		end
		chk("wait ended", n < 5000, 1'b1);
	endtask : wait_flag

	// Watchdog
	initial begin
		repeat (90000) @(posedge pclk);
		error_cnt++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, addr4_mode} = 5'h0;
		{paddr, pwdata, prot, region_lock} = '0;
		{error_cnt, comparisons, nbits} = '0;
		void'($urandom(32'h657ce298));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("reset status", {paused_flag, write_enable_latch, busy}, 3'h0);
		frame(`SFE_OP_SUSPEND, 3'd0, 1'b0, 32'h0);
		chk("idle suspend", paused_flag, 1'b0);
		frame(`SFE_OP_RESUME, 3'd0, 1'b0, 32'h0);
		chk("idle resume", busy, 1'b0);
		frame(`SFE_OP_WREN, 3'd0, 1'b0, 32'h0);
		frame(`SFE_OP_WRDI, 3'd0, 1'b0, 32'h0);
		chk("wel cleared", write_enable_latch, 1'b0);
		a = $urandom & 32'h00ff_ffff;
		frame(`SFE_OP_SE, 3'd3, 1'b0, a);
		chk("erase without wel", busy, 1'b0);
		frame(`SFE_OP_WREN, 3'd0, 1'b0, 32'h0);
		frame(`SFE_OP_SE4, 3'd3, 1'b0, a);
		frame(`SFE_OP_SE, 3'd4, 1'b0, a);
		chk("short or long frame", busy, 1'b0);
		for (int i = 0; i < 9; i++) begin
			op = ops[i % 7];
			a = $urandom & 32'h00ff_ffff;
			addr4_mode <= 1'($urandom);
			@(posedge pclk);
			erase(op, a);
			chk("busy running", busy, 1'b1);
			frame(`SFE_OP_RDSR, 3'd0, 1'b1, 32'h0);
			chk("status byte", last_st[15:8], 8'h03);
			if (nab_of(op) == 3'd0) frame(`SFE_OP_SUSPEND, 3'd0, 1'b0, 32'h0);
			chk("chip not paused", paused_flag, 1'b0);
			wait_flag(1'b1);
			chk("erase kind", {30'h0, erase_kind}, {30'h0, kind_of(op)});
			chk("erase base", erase_base, base_of(op, a));
			@(posedge pclk);
			chk("after erase", {busy, write_enable_latch}, 2'b00);
		end
		addr4_mode <= 1'b0;
		region_lock <= 16'h0001 << a[24:21];
		erase(`SFE_OP_SE, a);
		chk("locked sector", busy, 1'b0);
		erase(`SFE_OP_CE_A, 32'h0);
		chk("locked chip", busy, 1'b0);
		region_lock <= 16'h0;
		prot <= 6'h01;
		erase(`SFE_OP_SE4, a | 32'h0100_0000);
		chk("protected sector", busy, 1'b0);
		prot <= 6'h00;
		erase(`SFE_OP_BE32, a);
		frame(`SFE_OP_SUSPEND, 3'd0, 1'b0, 32'h0);
		chk("paused", paused_flag, 1'b1);
		wait_flag(1'b0);
		erase(`SFE_OP_SE, a ^ 32'h0000_8000);
		chk("erase while paused", {paused_flag, busy}, 2'b10);
		frame(8'h02, 3'd3, 1'b0, a);
		chk("program while paused", {paused_flag, busy}, 2'b10);
		frame(`SFE_OP_RESUME, 3'd0, 1'b0, 32'h0);
		chk("resumed", {paused_flag, busy}, 2'b01);
		// The frame itself outlasts the suspend latency after resume
		frame(`SFE_OP_SUSPEND, 3'd0, 1'b0, 32'h0);
		wait_flag(1'b0);
		frame(`SFE_OP_RESUME, 3'd0, 1'b0, 32'h0);
		wait_flag(1'b1);
		chk("kept kind", {30'h0, erase_kind}, {30'h0, sfe_pkg::SFE_K_B32});
		chk("kept base", erase_base, base_of(`SFE_OP_BE32, a));
		// Random protection settings over both halves of the array
		for (int i = 0; i < 4; i++) begin
			prot <= 6'($urandom);
			a = $urandom & 32'h01ff_ffff;
			erase(`SFE_OP_SE4, a);
			chk("random protect", busy, !prot_of(prot, a));
			if (busy === 1'b1) wait_flag(1'b1);
		end
		prot <= 6'h00;
		erase(`SFE_OP_BE32, a);
		frame(`SFE_OP_SUSPEND, 3'd0, 1'b0, 32'h0);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("power loss", paused_flag, 1'b0);
		frame(`SFE_OP_RESUME, 3'd0, 1'b0, 32'h0);
		chk("resume after loss", busy, 1'b0);
		tally_and_finish();
	end
endmodule : serial_flash_erase_suspend_resume_bench
